// ---- shared/bram_pkg.sv ----
package bram_pkg;
    // memory geometry
    localparam int CELL_BITS = 40960;
    localparam int HALF_BITS = 20480;
    localparam int TDP_HALF_MAX = 20;
    localparam int TDP_FULL_MAX = 40;
    localparam int SDP_FULL_MAX = 80;
    localparam int GROUP_WIDTH = 20;
    localparam int ADDR_WIDTH = 16;
    localparam int WORD_WIDTH = 40;
    localparam int WORDS = 1024;
    localparam int ECC_DATA = 32;
    localparam int ECC_PARITY = 7;
    localparam int ECC_CODE = 39;
    localparam int OUT_LATENCY_EXTRA = 1;
    // width select codes for the port width field
    localparam logic [2:0] WSEL_1 = 3'h0;
    localparam logic [2:0] WSEL_2 = 3'h1;
    localparam logic [2:0] WSEL_5 = 3'h2;
    localparam logic [2:0] WSEL_10 = 3'h3;
    localparam logic [2:0] WSEL_20 = 3'h4;
    localparam logic [2:0] WSEL_40 = 3'h5;
    localparam logic [2:0] WSEL_80 = 3'h6;
    // fifo thresholds
    localparam logic [9:0] ALMOST_EMPTY_RST = 10'h004;
    localparam logic [9:0] ALMOST_FULL_RST = 10'h3FC;
endpackage

// ---- verilog/configurable_dual_port_block_ram.sv ----
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// How it works
// - one 40K cell or two 20K halves
// - port width up to 40 or 80
// - only masked-in bits are written, except ecc writes, which store the whole word
// - optional output register adds one cycle
// - hamming 39,32 corrects one, detects two
// - ecc only in the 40K arrangement, at any width setting
// - ecc outcome shown on status outputs
// - half shapes; no 512x40 shape, cfgSimple is not used
// - low and high groups merge in 40K
// - control inputs chosen from two alternatives
// - forward stage picks cascade or fabric inputs
// - enable, write enable individually invertible; clock not invertible
// - mode stage maps groups onto macro ports
// - both ports work independently together
// - each port reaches whole memory
// - true dual width 20 split, 40 full
// - fifo pointers replace address inputs
// - fifo pushes on B, pops on A
// - fifo flags, pointers, active-low reset
// - cascade forwards data and mask too
// - contents preloaded at configuration
module configurable_dual_port_block_ram #(
    parameter int ADDR_W = bram_pkg::ADDR_WIDTH,
    parameter int GRP_W = bram_pkg::GROUP_WIDTH,
    parameter logic [bram_pkg::WORD_WIDTH-1:0] INIT_WORD = 40'h00_0000_0000
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // configuration
    input wire logic cfgSplit,
    input wire logic cfgSimple,
    input wire logic cfgEcc,
    input wire logic [1:0] cfgOutReg,
    input wire logic cfgFifo,
    input wire logic cfgCascade,
    input wire logic [3:0] cfgAltSel,
    input wire logic [3:0] cfgInvEn,
    input wire logic [3:0] cfgInvWe,
    input wire logic [2:0] cfgWidthA,
    input wire logic [2:0] cfgWidthB,
    // fabric groups: index 0 a_low, 1 a_high, 2 b_low, 3 b_high
    input wire logic [3:0] portEnableAlt1,
    input wire logic [3:0] portEnableAlt2,
    input wire logic [3:0] portWriteEnableAlt1,
    input wire logic [3:0] portWriteEnableAlt2,
    input wire logic [4*ADDR_W-1:0] portAddressAlt1,
    input wire logic [4*ADDR_W-1:0] portAddressAlt2,
    input wire logic [4*GRP_W-1:0] writeDataIn,
    input wire logic [4*GRP_W-1:0] writeBitMask,
    // cascade from the adjacent cell
    input wire logic cascadeEnable,
    input wire logic cascadeWriteEnable,
    input wire logic [ADDR_W-1:0] cascadeAddress,
    input wire logic cascadeData,
    input wire logic cascadeMask,
    // read data and ecc status per group
    output logic [4*GRP_W-1:0] readData,
    output logic [3:0] eccSingleFixed,
    output logic [3:0] eccDoubleFound,
    // fifo
    input wire logic fifoRstN,
    output logic fifoEmpty,
    output logic fifoFull,
    output logic fifoAlmostEmpty,
    output logic fifoAlmostFull,
    output logic fifoReadError,
    output logic fifoWriteError,
    output logic [9:0] fifoReadPtr,
    output logic [9:0] fifoWritePtr
);
    // one clock, so the per-port clock choice and inversion reduce to the enable path
    localparam int NW = bram_pkg::WORDS;

    // preload by initialiser so that storage keeps a single writing process
    logic [bram_pkg::WORD_WIDTH-1:0] memQ [NW] = '{default: INIT_WORD};
    logic en [4];
    logic we [4];
    logic [ADDR_W-1:0] addr [4];
    logic [GRP_W-1:0] din [4];
    logic [GRP_W-1:0] mask [4];
    logic [GRP_W-1:0] rawQ [4];
    logic [3:0] sErrQ, dErrQ;
    logic [GRP_W-1:0] outQ [4];
    logic [3:0] sOutQ, dOutQ;

    ////////////////////////////////////////////////////////////////////////////
    // forward selection, alternative choice and inversion

    // bits above the configured width reach storage only through ecc writes, which ignore the mask
    function automatic logic [GRP_W-1:0] laneMask(input logic [2:0] code);
        logic [GRP_W-1:0] m;
        m = '1;
        if (code == bram_pkg::WSEL_1) m = GRP_W'(20'h00001);
        else if (code == bram_pkg::WSEL_2) m = GRP_W'(20'h00003);
        else if (code == bram_pkg::WSEL_5) m = GRP_W'(20'h0001F);
        else if (code == bram_pkg::WSEL_10) m = GRP_W'(20'h003FF);
        // a group carries 20 bits at most; wider shapes join groups
        return m;
    endfunction

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : gSel
            logic enRaw, weRaw;
            logic [ADDR_W-1:0] adRaw;
            always_comb begin
                enRaw = cfgAltSel[g] ? portEnableAlt2[g] : portEnableAlt1[g];
                weRaw = cfgAltSel[g] ? portWriteEnableAlt2[g] : portWriteEnableAlt1[g];
                adRaw = cfgAltSel[g] ? portAddressAlt2[g*ADDR_W +: ADDR_W]
                                     : portAddressAlt1[g*ADDR_W +: ADDR_W];
                din[g] = writeDataIn[g*GRP_W +: GRP_W];
                mask[g] = writeBitMask[g*GRP_W +: GRP_W]
                          & laneMask((g < 2) ? cfgWidthA : cfgWidthB);
                if (cfgCascade && g == 0) begin
                    enRaw = cascadeEnable;
                    weRaw = cascadeWriteEnable;
                    adRaw = cascadeAddress;
                    din[g] = {{(GRP_W-1){1'b0}}, cascadeData};
                    mask[g] = {{(GRP_W-1){1'b0}}, cascadeMask};
                end
                en[g] = enRaw ^ cfgInvEn[g];
                we[g] = weRaw ^ cfgInvWe[g];
                addr[g] = adRaw;
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // fifo: B low pushes, A low pops
    logic [9:0] wPtrQ, rPtrQ;
    logic [10:0] countQ;
    logic push, pop;
    assign push = cfgFifo && en[2] && we[2];
    assign pop = cfgFifo && en[0] && !we[0];
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wPtrQ <= 10'h000;
            rPtrQ <= 10'h000;
            countQ <= 11'h000;
            fifoReadError <= 1'b0;
            fifoWriteError <= 1'b0;
        end else if (!fifoRstN) begin
            wPtrQ <= 10'h000;
            rPtrQ <= 10'h000;
            countQ <= 11'h000;
            fifoReadError <= 1'b0;
            fifoWriteError <= 1'b0;
        end else begin
            fifoWriteError <= push && countQ == 11'(NW);
            fifoReadError <= pop && countQ == 11'h000;
            if (push && countQ != 11'(NW)) wPtrQ <= wPtrQ + 10'h001;
            if (pop && countQ != 11'h000) rPtrQ <= rPtrQ + 10'h001;
            countQ <= countQ + 11'((push && countQ != 11'(NW)) ? 1 : 0)
                             - 11'((pop && countQ != 11'h000) ? 1 : 0);
        end
    end
    assign fifoEmpty = countQ == 11'h000;
    assign fifoFull = countQ == 11'(NW);
    assign fifoAlmostEmpty = countQ <= 11'(bram_pkg::ALMOST_EMPTY_RST);
    assign fifoAlmostFull = countQ >= 11'(bram_pkg::ALMOST_FULL_RST);
    assign fifoReadPtr = rPtrQ;
    assign fifoWritePtr = wPtrQ;

    ////////////////////////////////////////////////////////////////////////////
    // ecc: hamming over 32 data bits with overall parity
    function automatic logic [7:0] eccGen(input logic [31:0] d);
        logic [38:0] cw;
        logic [7:0] p;
        int k;
        cw = '0;
        p = '0;
        k = 0;
        for (int i = 1; i <= 38; i++) begin
            if ((i & (i - 1)) != 0) begin
                cw[i] = d[k];
                k++;
            end
        end
        for (int j = 0; j < 6; j++) begin
            for (int i = 1; i <= 38; i++) begin
                if (i[j]) p[j] = p[j] ^ cw[i];
            end
        end
        p[6] = ^d ^ ^p[5:0];
        p[7] = 1'b0;
        return p;
    endfunction

    // flips the data bit that sits at the codeword position named by the syndrome
    function automatic logic [31:0] eccFix(input logic [31:0] d, input logic [5:0] s);
        logic [31:0] r;
        int k;
        r = d;
        k = 0;
        for (int i = 1; i <= 38; i++) begin
            if ((i & (i - 1)) != 0) begin
                if (6'(i) == s) r[k] = ~r[k];
                k++;
            end
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // mode selection and storage; word address is per 20-bit lane pair
    logic [9:0] wordA [4];
    logic laneHi [4];
    generate
        for (g = 0; g < 4; g++) begin : gMap
            always_comb begin
                // in split mode each half uses its own lane; merged mode spans both
                laneHi[g] = cfgSplit ? g[0] : addr[g][0];
                wordA[g] = addr[g][ADDR_W-1 -: 10];
                if (cfgFifo) begin
                    wordA[g] = (g >= 2) ? wPtrQ : rPtrQ;
                    laneHi[g] = g[0];
                end
            end
        end
    endgenerate

    always_ff @(posedge sys_clk) begin
        // rst leaves contents alone, matching a configured preload
        for (int p = 0; p < 4; p++) begin
            if (en[p] && we[p] && !(cfgFifo && p < 2)) begin
                if (cfgEcc && !cfgSplit && p[0] == 1'b0) begin
                    memQ[wordA[p]] <= {eccGen({din[p+1][15:0], din[p][15:0]}),
                                       din[p+1][15:0], din[p][15:0]};
                end else begin
                    for (int b = 0; b < GRP_W; b++) begin
                        if (mask[p][b]) begin
                            memQ[wordA[p]][(laneHi[p] ? GRP_W : 0) + b] <= din[p][b];
                        end
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read path and ecc check
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            for (int p = 0; p < 4; p++) rawQ[p] <= '0;
            sErrQ <= 4'h0;
            dErrQ <= 4'h0;
        end else begin
            for (int p = 0; p < 4; p++) begin
                if (en[p] && !we[p]) begin
                    logic [39:0] w;
                    logic [7:0] syn;
                    logic [31:0] fx;
                    w = memQ[wordA[p]];
                    rawQ[p] <= laneHi[p] ? w[39:20] : w[19:0];
                    sErrQ[p] <= 1'b0;
                    dErrQ[p] <= 1'b0;
                    if (cfgEcc && !cfgSplit) begin
                        syn = eccGen(w[31:0]) ^ w[39:32];
                        fx = w[31:0];
                        // odd overall parity means one flipped bit, which the syndrome locates
                        if (^w[38:0]) begin
                            sErrQ[p] <= 1'b1;
                            fx = eccFix(w[31:0], syn[5:0]);
                        end else if (syn[5:0] != 6'h00) begin
                            dErrQ[p] <= 1'b1;
                        end
                        rawQ[p] <= p[0] ? {4'h0, fx[31:16]} : {4'h0, fx[15:0]};
                    end
                end
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            for (int p = 0; p < 4; p++) outQ[p] <= '0;
            sOutQ <= 4'h0;
            dOutQ <= 4'h0;
        end else begin
            for (int p = 0; p < 4; p++) outQ[p] <= rawQ[p];
            sOutQ <= sErrQ;
            dOutQ <= dErrQ;
        end
    end

    generate
        for (g = 0; g < 4; g++) begin : gOut
            logic useReg;
            assign useReg = cfgOutReg[g >> 1];
            assign readData[g*GRP_W +: GRP_W] = useReg ? outQ[g] : rawQ[g];
            assign eccSingleFixed[g] = useReg ? sOutQ[g] : sErrQ[g];
            assign eccDoubleFound[g] = useReg ? dOutQ[g] : dErrQ[g];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // checks
    a_fifo_ptr_rst: assert property (@(posedge sys_clk) disable iff (rst)
        !fifoRstN |=> fifoEmpty && fifoWritePtr == 10'h000)
        else $error("fifo not cleared by its reset");
    a_fifo_push_ptr: assert property (@(posedge sys_clk) disable iff (rst)
        fifoRstN && push && !fifoFull |=> fifoWritePtr == $past(fifoWritePtr) + 10'h001)
        else $error("push did not advance write pointer");
    a_fifo_over_err: assert property (@(posedge sys_clk) disable iff (rst)
        fifoRstN && push && fifoFull |=> fifoWriteError)
        else $error("overflow not flagged");
    a_read_latency: assert property (@(posedge sys_clk) disable iff (rst)
        en[1] && !we[1] && cfgSplit && !cfgEcc ##0 cfgOutReg[0] == 1'b0
        |=> readData[GRP_W +: GRP_W] == rawQ[1])
        else $error("read data not direct");
    a_out_reg_delay: assert property (@(posedge sys_clk) disable iff (rst)
        cfgOutReg[0] && $stable(cfgOutReg) |=> readData[0 +: GRP_W] == $past(rawQ[0]))
        else $error("output register not one cycle late");
    a_ecc_exclusive: assert property (@(posedge sys_clk) disable iff (rst)
        !(eccSingleFixed[0] && eccDoubleFound[0]))
        else $error("single and double error both set");
    a_ecc_off_quiet: assert property (@(posedge sys_clk) disable iff (rst)
        !cfgEcc && en[0] && !we[0] |=> !sErrQ[0] && !dErrQ[0])
        else $error("ecc flag without ecc");
    a_fifo_under_err: assert property (@(posedge sys_clk) disable iff (rst)
        fifoRstN && pop && fifoEmpty |=> fifoReadError && fifoReadPtr == $past(fifoReadPtr))
        else $error("underflow not handled");


    a_fifo_pop_ptr: assert property (@(posedge sys_clk) disable iff (rst)
        fifoRstN && pop && !fifoEmpty |=> fifoReadPtr == $past(fifoReadPtr) + 10'h001)
        else $error("pop did not advance read pointer");
    a_fifo_full_hold: assert property (@(posedge sys_clk) disable iff (rst)
        fifoRstN && push && fifoFull |=> fifoWritePtr == $past(fifoWritePtr))
        else $error("write pointer moved on overflow");
    a_fifo_push_idle: assert property (@(posedge sys_clk) disable iff (rst)
        fifoRstN && !push |=> fifoWritePtr == $past(fifoWritePtr))
        else $error("write pointer moved without push");
    a_fifo_pop_idle: assert property (@(posedge sys_clk) disable iff (rst)
        fifoRstN && !pop |=> fifoReadPtr == $past(fifoReadPtr))
        else $error("read pointer moved without pop");
    a_fifo_reset_rd: assert property (@(posedge sys_clk) disable iff (rst)
        !fifoRstN |=> fifoReadPtr == 10'h000 && !fifoReadError && !fifoWriteError)
        else $error("fifo read side not cleared");
    a_fifo_flag_order: assert property (@(posedge sys_clk) disable iff (rst)
        fifoEmpty |-> fifoAlmostEmpty && !fifoFull)
        else $error("empty flag inconsistent");
    a_fifo_almost_full: assert property (@(posedge sys_clk) disable iff (rst)
        fifoFull |-> fifoAlmostFull)
        else $error("full without almost full");

    // masked-in bits of a plain split write land in the addressed word
    a_write_lands: assert property (@(posedge sys_clk) disable iff (rst)
        cfgSplit && !cfgFifo && en[0] && we[0] && !(en[2] && we[2])
        |=> (memQ[$past(wordA[0])][19:0] & $past(mask[0])) == ($past(din[0]) & $past(mask[0])))
        else $error("masked write did not land");
    a_ecc_parity: assert property (@(posedge sys_clk) disable iff (rst)
        cfgEcc && !cfgSplit && !cfgFifo && en[0] && we[0]
        && !(en[1] && we[1]) && !(en[2] && we[2]) && !(en[3] && we[3])
        |=> memQ[$past(wordA[0])][39:32] == eccGen(memQ[$past(wordA[0])][31:0]))
        else $error("stored parity does not match data");
    a_no_access_hold: assert property (@(posedge sys_clk) disable iff (rst)
        !en[0] |=> rawQ[0] == $past(rawQ[0]))
        else $error("read data changed without access");
    a_ecc_split_quiet: assert property (@(posedge sys_clk) disable iff (rst)
        cfgSplit && en[0] && !we[0] |=> !sErrQ[0] && !dErrQ[0])
        else $error("ecc flag in split arrangement");

    c_fifo_full: cover property (@(posedge sys_clk) disable iff (rst) fifoFull);
    c_ecc_double: cover property (@(posedge sys_clk) disable iff (rst) eccDoubleFound[0]);
    c_out_reg_read: cover property (@(posedge sys_clk) disable iff (rst)
        cfgOutReg[0] && en[0] && !we[0]);
    c_ecc_fix: cover property (@(posedge sys_clk) disable iff (rst) eccSingleFixed[0]);
    c_both_ports: cover property (@(posedge sys_clk) disable iff (rst) en[0] && en[2]);
endmodule

// ---- sim/fabric_port_model.sv ----
`timescale 1ns/1ps
module fabric_port_model #(
    parameter int ADDR_W = 16,
    parameter int GRP_W = 20
) (
    // clock
    input wire logic sys_clk,
    // request lines towards the memory groups
    output logic [3:0] en,
    output logic [3:0] we,
    output logic [4*ADDR_W-1:0] addr,
    output logic [4*GRP_W-1:0] data,
    output logic [4*GRP_W-1:0] mask
);
    initial begin
        en = 4'h0;
        we = 4'h0;
        addr = '0;
        data = '0;
        mask = '0;
    end
    ////////////////////////////////////////
    // called just after an edge; the request is taken at the next edge
    task issue(input int g, input logic w, input logic [ADDR_W-1:0] a,
            input logic [GRP_W-1:0] d, input logic [GRP_W-1:0] m);
        en <= 4'h1 << g;
        we <= {3'h0, w} << g;
        addr[g*ADDR_W +: ADDR_W] <= a;
        data[g*GRP_W +: GRP_W] <= d;
        mask[g*GRP_W +: GRP_W] <= m;
        @(posedge sys_clk);
    endtask
    // released data lines must not keep looking valid
    task idle();
        en <= 4'h0;
        we <= 4'h0;
        data <= ~data;
        @(posedge sys_clk);
    endtask
endmodule

// ---- sim/configurable_dual_port_block_ram_bench.sv ----
`timescale 1ns/1ps
`define CHECK(what, exp, got) \
    begin \
        nCompared++; \
        if ((got) !== (exp)) begin \
            miscompares++; \
            $display("wrong value %s expected %h seen %h", what, exp, got); \
        end \
    end
module configurable_dual_port_block_ram_bench;
    // equal halves so the preload reads the same whichever lane serves a group
    localparam logic [39:0] INIT = 40'h12345_12345;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic cfgOutRegBit = 1'b0;
    logic cfgSplit = 1'b1;
    logic cfgEcc = 1'b0;
    logic [3:0] eccSingle;
    logic [3:0] eccDouble;
    logic cfgFifo = 1'b0;
    logic [3:0] cfgAltSel = 4'h0;
    logic [3:0] cfgInvEn = 4'h0;
    logic fifoRstN = 1'b1;
    logic [3:0] en;
    logic [3:0] we;
    logic [63:0] addr;
    logic [79:0] data;
    logic [79:0] mask;
    logic [79:0] readData;
    logic [9:0] fifoReadPtr;
    logic [9:0] fifoWritePtr;
    logic fifoEmpty;
    logic fifoAlmostEmpty;
    logic fifoFull;
    logic fifoReadError;
    int miscompares = 0;
    int nCompared = 0;
    always #4 sys_clk = ~sys_clk;
    fabric_port_model fab (.sys_clk(sys_clk), .en(en), .we(we), .addr(addr), .data(data),
        .mask(mask));
    // alt2 of each group carries the next group's request, so selection shows
    configurable_dual_port_block_ram #(.INIT_WORD(INIT)) dut_u (
        .sys_clk(sys_clk), .rst(rst), .cfgSplit(cfgSplit), .cfgSimple(cfgFifo), .cfgEcc(cfgEcc),
        .cfgOutReg({1'b0, cfgOutRegBit}), .cfgFifo(cfgFifo), .cfgCascade(1'b0),
        .cfgAltSel(cfgAltSel), .cfgInvEn(cfgInvEn), .cfgInvWe(4'h0),
        .cfgWidthA(bram_pkg::WSEL_20), .cfgWidthB(bram_pkg::WSEL_20),
        .portEnableAlt1(en), .portEnableAlt2({en[0], en[3:1]}),
        .portWriteEnableAlt1(we), .portWriteEnableAlt2({we[0], we[3:1]}),
        .portAddressAlt1(addr), .portAddressAlt2({addr[15:0], addr[63:16]}),
        .writeDataIn(data), .writeBitMask(mask),
        .cascadeEnable(en[3]), .cascadeWriteEnable(we[3]), .cascadeAddress(addr[63:48]),
        .cascadeData(data[60]), .cascadeMask(mask[60]),
        .readData(readData), .eccSingleFixed(eccSingle), .eccDoubleFound(eccDouble),
        .fifoRstN(fifoRstN), .fifoEmpty(fifoEmpty), .fifoFull(fifoFull),
        .fifoAlmostEmpty(fifoAlmostEmpty), .fifoAlmostFull(), .fifoReadError(fifoReadError),
        .fifoWriteError(), .fifoReadPtr(fifoReadPtr), .fifoWritePtr(fifoWritePtr));
    ////////////////////////////////////////
    task stop_test();
        $display("compared %0d mismatches %0d", nCompared, miscompares);
        if (miscompares == 0 && nCompared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task testReadWrite();
        `CHECK("fifoEmpty", 1'b1, fifoEmpty)
        `CHECK("fifoAlmostEmpty", 1'b1, fifoAlmostEmpty)
        `CHECK("fifoFull", 1'b0, fifoFull)
        fab.issue(0, 1'b0, 16'h00C0, 20'h0, 20'h0);
        #1;
        `CHECK("preload", INIT[19:0], readData[19:0])
        fab.issue(0, 1'b1, 16'h0040, 20'hABCDE, 20'hFFFFF);
        fab.issue(0, 1'b0, 16'h0040, 20'h0, 20'h0);
        #1;
        `CHECK("readBack", 20'hABCDE, readData[19:0])
        $display("test read write done");
    endtask
    task testInvert();
        cfgInvEn <= 4'h1;
        fab.issue(0, 1'b0, 16'h00C0, 20'h0, 20'h0);
        #1;
        `CHECK("noAccess", 20'hABCDE, readData[19:0])
        fab.idle();
        #1;
        `CHECK("invRead", INIT[19:0], readData[19:0])
        cfgInvEn <= 4'h0;
        $display("test invert done");
    endtask
    task testMaskOutReg();
        fab.issue(0, 1'b1, 16'h0080, 20'hFFFFF, 20'hFFFFF);
        fab.issue(0, 1'b1, 16'h0080, 20'h00000, 20'h0000F);
        fab.issue(0, 1'b0, 16'h0080, 20'h0, 20'h0);
        #1;
        `CHECK("masked", 20'hFFFF0, readData[19:0])
        cfgOutRegBit <= 1'b1;
        fab.issue(0, 1'b1, 16'h0140, 20'h13579, 20'hFFFFF);
        fab.issue(0, 1'b0, 16'h0140, 20'h0, 20'h0);
        #1;
        `CHECK("early", 1'b1, readData[19:0] !== 20'h13579)
        fab.idle();
        #1;
        `CHECK("late", 20'h13579, readData[19:0])
        cfgOutRegBit <= 1'b0;
        $display("test mask and output register done");
    endtask
    task testCrossAlt();
        fab.issue(2, 1'b1, 16'h0180, 20'h2468A, 20'hFFFFF);
        fab.issue(0, 1'b0, 16'h0180, 20'h0, 20'h0);
        #1;
        `CHECK("crossPort", 20'h2468A, readData[19:0])
        fab.issue(0, 1'b1, 16'h01C0, 20'h0F0F0, 20'hFFFFF);
        cfgAltSel <= 4'h1;
        fab.issue(1, 1'b0, 16'h01C0, 20'h0, 20'h0);
        #1;
        `CHECK("altInput", 20'h0F0F0, readData[19:0])
        cfgAltSel <= 4'h0;
        $display("test cross port and alternate inputs done");
    endtask
    task testEcc();
        cfgSplit <= 1'b0;
        cfgEcc <= 1'b1;
        fab.issue(0, 1'b1, 16'h0200, 20'h0A5C3, 20'hFFFFF);
        cfgEcc <= 1'b0;
        fab.issue(0, 1'b1, 16'h0200, 20'h00004, 20'h00004);
        cfgEcc <= 1'b1;
        fab.issue(0, 1'b0, 16'h0200, 20'h0, 20'h0);
        #1;
        `CHECK("eccFixed", 20'h0A5C3, readData[19:0])
        `CHECK("eccSingle", 1'b1, eccSingle[0])
        cfgEcc <= 1'b0;
        fab.issue(0, 1'b1, 16'h0200, 20'h00008, 20'h00008);
        cfgEcc <= 1'b1;
        fab.issue(0, 1'b0, 16'h0200, 20'h0, 20'h0);
        #1;
        `CHECK("eccDouble", 1'b1, eccDouble[0])
        `CHECK("eccNotSingle", 1'b0, eccSingle[0])
        cfgEcc <= 1'b0;
        cfgSplit <= 1'b1;
        $display("test ecc done");
    endtask
    task testFifo();
        cfgFifo <= 1'b1;
        fifoRstN <= 1'b0;
        fab.idle();
        fifoRstN <= 1'b1;
        fab.issue(0, 1'b0, 16'h0000, 20'h0, 20'h0);
        #1;
        `CHECK("popEmptyErr", 1'b1, fifoReadError)
        `CHECK("popEmptyPtr", 10'h000, fifoReadPtr)
        fab.issue(2, 1'b1, 16'h0FC0, 20'h55555, 20'hFFFFF);
        #1;
        `CHECK("pushPtr", 10'h001, fifoWritePtr)
        `CHECK("notEmpty", 1'b0, fifoEmpty)
        `CHECK("errOnce", 1'b0, fifoReadError)
        fab.issue(0, 1'b0, 16'h0FC0, 20'h0, 20'h0);
        #1;
        `CHECK("popPtr", 10'h001, fifoReadPtr)
        `CHECK("popData", 20'h55555, readData[19:0])
        `CHECK("emptyAgain", 1'b1, fifoEmpty)
        fifoRstN <= 1'b0;
        fab.idle();
        #1;
        `CHECK("fifoCleared", 10'h000, fifoWritePtr)
        fifoRstN <= 1'b1;
        cfgFifo <= 1'b0;
        $display("test fifo done");
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        #1;
        testReadWrite();
        testInvert();
        testMaskOutReg();
        testCrossAlt();
        testEcc();
        testFifo();
        stop_test();
    end
    // hang guard
    initial begin
        #100000;
        miscompares++;
        stop_test();
    end
endmodule
